// *** shared/dmcore_pkg.sv ***
`default_nettype none
package dmcore_pkg;
  // data memory locations of the core special registers
  localparam logic [7:0] ADR_WIN0  = 8'h00;
  localparam logic [7:0] ADR_PTR0  = 8'h01;
  localparam logic [7:0] ADR_WIN1  = 8'h02;
  localparam logic [7:0] ADR_PTR1  = 8'h03;
  localparam logic [7:0] ADR_BANK  = 8'h04;
  localparam logic [7:0] ADR_ACC   = 8'h05;
  localparam logic [7:0] ADR_PCL   = 8'h06;
  localparam logic [7:0] ADR_TBLP  = 8'h07;
  localparam logic [7:0] ADR_TABLE_HIGH_LATCH  = 8'h08;
  localparam logic [7:0] ADR_FLAGS = 8'h0a;
  // general purpose area, bank 0 only
  localparam logic [7:0] GP_BASE   = 8'h40;
  localparam logic [7:0] GP_LAST   = 8'h7f;
  localparam int unsigned GP_WORDS = 64;
  // bus geometry: byte address is four times the location
  localparam int unsigned AXI_AW   = 32;
  localparam int unsigned LOC_LSB  = 2;
  localparam int unsigned LOC_MSB  = 9;
  // flag bit positions
  localparam int unsigned FLG_C    = 0;
  localparam int unsigned FLG_HC   = 1;
  localparam int unsigned FLG_Z    = 2;
  localparam int unsigned FLG_OV   = 3;
  localparam int unsigned FLG_SLP  = 4;
  localparam int unsigned FLG_WDT  = 5;
  localparam logic [7:0] FLAGS_SW_MASK = 8'h0f;
  // reset values
  localparam logic [7:0] BYTE_RST  = 8'h00;
  localparam logic       BANK_RST  = 1'b0;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // program memory word and high latch
  localparam int unsigned PROG_W   = 15;
  localparam int unsigned PAGE_W   = PROG_W - 8;

  typedef enum logic [2:0] {
    DMCORE_ADD = 3'h0,
    DMCORE_SUB = 3'h1,
    DMCORE_AND = 3'h2,
    DMCORE_OR  = 3'h3,
    DMCORE_XOR = 3'h4,
    DMCORE_RLC = 3'h5,
    DMCORE_RRC = 3'h6,
    DMCORE_LDA = 3'h7
  } dmcore_alu_op_t;

  typedef struct packed {
    logic           valid;
    dmcore_alu_op_t op;
    logic [7:0]     operand;
  } dmcore_alu_req_t;

  typedef struct packed {
    logic              valid;
    logic [PROG_W-1:0] word;
    logic [7:0]        dest;
  } dmcore_tab_req_t;

  typedef struct packed {
    logic              watchdog_clear_instruction;
    logic              halt;
    logic              wdt_timeout;
    logic              wdt_reset;
    logic              in_power_down;
  } dmcore_sys_ev_t;

  typedef struct packed {
    logic [GP_WORDS-1:0][7:0] ram;
    logic [7:0]        mp0;
    logic [7:0]        mp1;
    logic              bank;
    logic [7:0]        acc;
    logic [7:0]        program_counter_low_byte;
    logic [7:0]        tblp;
    logic [PAGE_W-1:0] table_high_latch;
    logic [5:0]        flags;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [7:0]        rdata;
    logic [7:0]        rloc;
    logic              jump;
    logic              dummy;
  } dmcore_state_t;
endpackage
`default_nettype wire

// *** rtl/dmcore_top.sv ***
// Behaviour
// (RULE_01) window access acts on the location held in its paired pointer
// (RULE_02) window reached through a window reads 00h, writes do nothing
// (RULE_03) window 0 reaches bank 0 only; window 1 reaches selected bank
// (RULE_04) direct accesses always go to bank 0
// (RULE_05) bank select uses bit 0 only; bits 7..1 read zero
// (RULE_06) resets clear bank select, except watchdog reset in power-down
// (RULE_07) special registers decode the same in every bank
// (RULE_08) unused special locations read zero
// (RULE_09) alu results land in accumulator; no register-to-register path
// (RULE_10) writing pc low byte jumps in page and adds one dummy cycle
// (RULE_11) table read: high part to latch, low byte to named destination
// (RULE_12) table pointer is a plain read/write register, loaded before reads
// (RULE_13) flag writes change arithmetic flags, never watchdog or sleep flags
// (RULE_14) carry: add carry out, subtract no borrow, rotates through carry
// (RULE_15) half carry: low nibble carry, or no borrow into low nibble
// (RULE_16) zero flag set when arithmetic or logic result is zero
// (RULE_17) overflow when carry into top bit differs from carry out
// (RULE_18) sleep flag clears on power-up or watchdog clear, sets on halt
// (RULE_19) watchdog flag clears on power-up, clear or halt; sets on timeout
// (RULE_20) watchdog flag bit 5, sleep flag bit 4, bits 7..6 read zero
// (RULE_21) interrupts and calls do not save the flags register
// (RULE_22) window pointer at a special location reaches it in any bank
//
// The AXI4-Lite slave port was decided locally.
`default_nettype none
module dmcore_top (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic [dmcore_pkg::AXI_AW-1:0] s_axi_awaddr,
  input  wire logic [2:0]                 s_axi_awprot,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [dmcore_pkg::AXI_AW-1:0] s_axi_araddr,
  input  wire logic [2:0]                 s_axi_arprot,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  input  wire dmcore_pkg::dmcore_alu_req_t alu_req,
  input  wire dmcore_pkg::dmcore_tab_req_t tab_req,
  input  wire dmcore_pkg::dmcore_sys_ev_t  sys_ev,
  input  wire logic [dmcore_pkg::PAGE_W-1:0] pc_page,
  output logic [dmcore_pkg::PROG_W-1:0]   table_addr,
  output logic                            pc_jump,
  output logic [7:0]                      pc_target,
  output logic                            dummy_cycle,
  output logic [7:0]                      acc_value,
  output logic [7:0]                      flags_value
);
  import dmcore_pkg::*;

  dmcore_state_t st_q;
  dmcore_state_t st_d;
  logic          wr_take;
  logic          rd_take;
  logic [7:0]    wr_loc;
  logic [7:0]    rd_loc;
  logic          wr_in_map;
  logic          rd_in_map;

  // read of one location; windows themselves read zero here
  function automatic logic [7:0] read_loc(input dmcore_state_t s, input logic [7:0] a,
                                          input logic bnk);
    logic [7:0] v;
    v = 8'h00;
    if (a < GP_BASE)                                 // RULE_07 RULE_22
    begin
      case (a)
        ADR_PTR0:  v = s.mp0;
        ADR_PTR1:  v = s.mp1;
        ADR_BANK:  v = {7'h00, s.bank};              // RULE_05
        ADR_ACC:   v = s.acc;
        ADR_PCL:   v = s.program_counter_low_byte;
        ADR_TBLP:  v = s.tblp;
        ADR_TABLE_HIGH_LATCH:  v = {{(8-PAGE_W){1'b0}}, s.table_high_latch};
        ADR_FLAGS: v = {2'b00, s.flags};             // RULE_20
        default:   v = 8'h00;                        // RULE_02 RULE_08
      endcase
    end
    else if (!bnk && a <= GP_LAST)
    begin
      v = s.ram[6'(a - GP_BASE)];
    end
    return v;
  endfunction

  // resolved target of an access: windows follow their pointers
  function automatic logic [8:0] resolve(input dmcore_state_t s, input logic [7:0] a);
    logic [8:0] r;
    r = {1'b0, a};                                   // RULE_04
    if (a == ADR_WIN0)
    begin
      r = {1'b0, s.mp0};                             // RULE_01 RULE_03
    end
    else if (a == ADR_WIN1)
    begin
      r = {s.bank, s.mp1};                           // RULE_01 RULE_03
    end
    return r;
  endfunction

  // write of one resolved location
  function automatic dmcore_state_t write_loc(input dmcore_state_t s, input logic [7:0] a,
                                              input logic bnk, input logic [7:0] v);
    dmcore_state_t n;
    n = s;
    if (a < GP_BASE)                                 // RULE_07 RULE_22
    begin
      case (a)
        ADR_PTR0: n.mp0 = v;
        ADR_PTR1: n.mp1 = v;
        ADR_BANK: n.bank = v[0];                     // RULE_05
        ADR_ACC:  n.acc = v;
        ADR_PCL:
        begin
          n.program_counter_low_byte  = v;                                // RULE_10
          n.jump = 1'b1;
        end
        ADR_TBLP: n.tblp = v;                        // RULE_12
        ADR_FLAGS:
        begin
          n.flags[3:0] = v[3:0] & FLAGS_SW_MASK[3:0]; // RULE_13
        end
        default:  n = s;                             // RULE_02 windows, latch, unused
      endcase
    end
    else if (!bnk && a <= GP_LAST)
    begin
      n.ram[6'(a - GP_BASE)] = v;
    end
    return n;
  endfunction

  // alu datapath; only the accumulator and flags take results
  function automatic dmcore_state_t alu_step(input dmcore_state_t s, input dmcore_alu_req_t q);
    dmcore_state_t n;
    logic [7:0]    b;
    logic          cin;
    logic [8:0]    sum;
    logic [4:0]    nib;
    logic [7:0]    low7;
    logic [7:0]    res;
    n    = s;
    b    = (q.op == DMCORE_SUB) ? ~q.operand : q.operand;
    cin  = (q.op == DMCORE_SUB);
    sum  = {1'b0, s.acc} + {1'b0, b} + {8'h00, cin};
    nib  = {1'b0, s.acc[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    low7 = {1'b0, s.acc[6:0]} + {1'b0, b[6:0]} + {7'h00, cin};
    res  = s.acc;
    case (q.op)
      DMCORE_ADD, DMCORE_SUB:
      begin
        res                = sum[7:0];
        n.flags[FLG_C]     = sum[8];                 // RULE_14
        n.flags[FLG_HC]    = nib[4];                 // RULE_15
        n.flags[FLG_OV]    = low7[7] ^ sum[8];       // RULE_17
        n.flags[FLG_Z]     = (sum[7:0] == 8'h00);    // RULE_16
      end
      DMCORE_AND, DMCORE_OR, DMCORE_XOR:
      begin
        res = (q.op == DMCORE_AND) ? (s.acc & q.operand) :
              (q.op == DMCORE_OR)  ? (s.acc | q.operand) : (s.acc ^ q.operand);
        n.flags[FLG_Z] = (res == 8'h00);             // RULE_16
      end
      DMCORE_RLC:
      begin
        res            = {s.acc[6:0], s.flags[FLG_C]};
        n.flags[FLG_C] = s.acc[7];                   // RULE_14
      end
      DMCORE_RRC:
      begin
        res            = {s.flags[FLG_C], s.acc[7:1]};
        n.flags[FLG_C] = s.acc[0];                   // RULE_14
      end
      default: res = q.operand;
    endcase
    n.acc = res;                                     // RULE_09
    return n;
  endfunction

  // bus handshakes: one write and one read at a time
  assign wr_take       = s_axi_awvalid && s_axi_wvalid && !st_q.bvalid;
  assign rd_take       = s_axi_arvalid && !st_q.rvalid;
  assign s_axi_awready = wr_take;
  assign s_axi_wready  = wr_take;
  assign s_axi_arready = rd_take;
  assign wr_loc        = s_axi_awaddr[LOC_MSB:LOC_LSB];
  assign rd_loc        = s_axi_araddr[LOC_MSB:LOC_LSB];
  assign wr_in_map     = (s_axi_awaddr[AXI_AW-1:LOC_MSB+1] == '0);
  assign rd_in_map     = (s_axi_araddr[AXI_AW-1:LOC_MSB+1] == '0);

  // registered outputs, except table_addr whose page part is pc_page taken straight through
  assign s_axi_bvalid  = st_q.bvalid;
  assign s_axi_bresp   = st_q.bresp;
  assign s_axi_rvalid  = st_q.rvalid;
  assign s_axi_rresp   = st_q.rresp;
  assign s_axi_rdata   = {24'h000000, st_q.rdata};
  assign pc_jump       = st_q.jump;
  assign pc_target     = st_q.program_counter_low_byte;
  assign dummy_cycle   = st_q.dummy;
  assign acc_value     = st_q.acc;
  assign flags_value   = {2'b00, st_q.flags};        // RULE_20
  assign table_addr    = {pc_page, st_q.tblp};       // RULE_11

  // next state: bus, table read, alu, system events, resets
  always_comb
  begin
    logic [8:0] tgt;
    tgt        = 9'h000;
    st_d       = st_q;
    st_d.dummy = st_q.jump;                          // RULE_10
    st_d.jump  = 1'b0;
    if (st_q.bvalid && s_axi_bready)
    begin
      st_d.bvalid = 1'b0;
    end
    if (st_q.rvalid && s_axi_rready)
    begin
      st_d.rvalid = 1'b0;
    end
    if (wr_take)
    begin
      st_d.bvalid = 1'b1;
      st_d.bresp  = wr_in_map ? RESP_OKAY : RESP_SLVERR;
      if (wr_in_map && s_axi_wstrb[0])
      begin
        tgt  = resolve(st_q, wr_loc);
        st_d = write_loc(st_d, tgt[7:0], tgt[8], s_axi_wdata[7:0]);
      end
    end
    if (rd_take)
    begin
      tgt         = resolve(st_q, rd_loc);
      st_d.rvalid = 1'b1;
      st_d.rloc   = rd_loc;
      st_d.rresp  = rd_in_map ? RESP_OKAY : RESP_SLVERR;
      st_d.rdata  = rd_in_map ? read_loc(st_q, tgt[7:0], tgt[8]) : 8'h00;
    end
    if (tab_req.valid)
    begin
      st_d.table_high_latch = tab_req.word[PROG_W-1:8];          // RULE_11
      tgt       = resolve(st_q, tab_req.dest);
      st_d      = write_loc(st_d, tgt[7:0], tgt[8], tab_req.word[7:0]);
    end
    if (alu_req.valid)
    begin
      st_d = alu_step(st_d, alu_req);                // RULE_09
    end
    // clears first so that a timeout in the same cycle still sets
    if (sys_ev.watchdog_clear_instruction)
    begin
      st_d.flags[FLG_SLP] = 1'b0;                    // RULE_18
      st_d.flags[FLG_WDT] = 1'b0;                    // RULE_19
    end
    if (sys_ev.halt)
    begin
      st_d.flags[FLG_SLP] = 1'b1;                    // RULE_18
      st_d.flags[FLG_WDT] = 1'b0;                    // RULE_19
    end
    if (sys_ev.wdt_timeout || sys_ev.wdt_reset)
    begin
      st_d.flags[FLG_WDT] = 1'b1;                    // RULE_19
    end
    if (sys_ev.wdt_reset && !sys_ev.in_power_down)
    begin
      st_d.bank = BANK_RST;                          // RULE_06
    end
    // flags are never stacked: no path saves them on calls   RULE_21
  end

  // single state register, synchronous power-on reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_q       <= '0;
      st_q.bank  <= BANK_RST;                        // RULE_06
      st_q.flags <= 6'h00;                           // RULE_18 RULE_19
      st_q.bresp <= RESP_OKAY;
      st_q.rresp <= RESP_OKAY;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_bank_upper_zero: assert property (st_q.rvalid && st_q.rloc == ADR_BANK   // RULE_05
    |-> st_q.rdata[7:1] == 7'h00) else $error("bank select upper bits not zero");
  a_window_self_read: assert property (rd_take && rd_in_map && rd_loc == ADR_WIN0 // RULE_02
    && (st_q.mp0 == ADR_WIN0 || st_q.mp0 == ADR_WIN1) |=> st_q.rdata == 8'h00)
    else $error("window read through window not zero");
  a_bank_wdt_reset: assert property (sys_ev.wdt_reset && !sys_ev.in_power_down // RULE_06
    |=> !st_q.bank) else $error("bank select not cleared by watchdog reset");
  a_bank_pd_keep: assert property (sys_ev.wdt_reset && sys_ev.in_power_down    // RULE_06
    && !wr_take && !tab_req.valid |=> $stable(st_q.bank))
    else $error("bank select changed by power-down watchdog reset");
  a_flags_sys_guard: assert property (!sys_ev.watchdog_clear_instruction && !sys_ev.halt          // RULE_13
    && !sys_ev.wdt_timeout && !sys_ev.wdt_reset |=> $stable(st_q.flags[5:4]))
    else $error("system flags changed without system event");
  a_pcl_jump_seq: assert property (wr_take && wr_in_map && s_axi_wstrb[0]      // RULE_10
    && wr_loc == ADR_PCL |=> pc_jump && pc_target == $past(s_axi_wdata[7:0]) ##1 dummy_cycle)
    else $error("pc low write did not jump then insert dummy cycle");
  a_table_high: assert property (tab_req.valid                                 // RULE_11
    |=> st_q.table_high_latch == $past(tab_req.word[PROG_W-1:8]))
    else $error("table high latch not loaded");
  a_acc_add: assert property (alu_req.valid && alu_req.op == DMCORE_ADD        // RULE_09
    && !tab_req.valid && !wr_take
    |=> st_q.acc == 8'($past(st_q.acc) + $past(alu_req.operand)))
    else $error("accumulator add result wrong");
  a_zero_logic: assert property (alu_req.valid                                 // RULE_16
    && alu_req.op inside {DMCORE_AND, DMCORE_OR, DMCORE_XOR}
    |=> st_q.flags[FLG_Z] == (st_q.acc == 8'h00))
    else $error("zero flag disagrees with result");
  a_halt_flags: assert property (sys_ev.halt && !sys_ev.wdt_timeout            // RULE_18
    && !sys_ev.wdt_reset |=> st_q.flags[FLG_SLP] && !st_q.flags[FLG_WDT])
    else $error("halt did not set sleep flag and clear watchdog flag");
  a_timeout_wins: assert property (sys_ev.wdt_timeout                           // RULE_19
    |=> st_q.flags[FLG_WDT]) else $error("watchdog flag not set by timeout");
  a_bus_answer: assert property (wr_take |=> s_axi_bvalid)
    else $error("write response missing");
  a_read_answer: assert property (rd_take |=> s_axi_rvalid)
    else $error("read response missing");

  // alu flag checks, operands taken before the step
  a_sub_carry: assert property (alu_req.valid && alu_req.op == DMCORE_SUB      // RULE_14
    && !tab_req.valid && !wr_take
    |=> st_q.flags[FLG_C] == ($past(st_q.acc) >= $past(alu_req.operand)))
    else $error("carry after subtract wrong");
  a_add_half_carry: assert property (alu_req.valid && alu_req.op == DMCORE_ADD // RULE_15
    && !tab_req.valid && !wr_take
    |=> st_q.flags[FLG_HC] == (5'($past(st_q.acc[3:0])) + 5'($past(alu_req.operand[3:0]))
    > 5'h0f))
    else $error("half carry after add wrong");
  a_add_wrap: assert property (alu_req.valid && alu_req.op == DMCORE_ADD       // RULE_17
    && !tab_req.valid && !wr_take
    |=> st_q.flags[FLG_OV] == ($past(st_q.acc[7]) == $past(alu_req.operand[7])
    && st_q.acc[7] != $past(st_q.acc[7])))
    else $error("signed wrap after add wrong");
  a_rotate_left: assert property (alu_req.valid && alu_req.op == DMCORE_RLC    // RULE_14
    && !tab_req.valid && !wr_take
    |=> st_q.flags[FLG_C] == $past(st_q.acc[7])
    && st_q.acc == {$past(st_q.acc[6:0]), $past(st_q.flags[FLG_C])})
    else $error("rotate through carry wrong");

  // software and system side of the flags register
  a_sw_flag_write: assert property (wr_take && wr_in_map && s_axi_wstrb[0]    // RULE_13
    && wr_loc == ADR_FLAGS && !alu_req.valid && !tab_req.valid
    && !sys_ev.watchdog_clear_instruction && !sys_ev.halt && !sys_ev.wdt_timeout && !sys_ev.wdt_reset
    |=> st_q.flags[3:0] == $past(s_axi_wdata[3:0]) && $stable(st_q.flags[5:4]))
    else $error("flag write reached wrong bits");
  a_clr_flags: assert property (sys_ev.watchdog_clear_instruction && !sys_ev.halt                 // RULE_18
    && !sys_ev.wdt_timeout && !sys_ev.wdt_reset
    |=> !st_q.flags[FLG_SLP] && !st_q.flags[FLG_WDT])
    else $error("watchdog clear left a system flag set");

  // direct and window writes into bank 0 storage
  a_direct_bank0: assert property (wr_take && wr_in_map && s_axi_wstrb[0]     // RULE_04
    && wr_loc >= GP_BASE && wr_loc <= GP_LAST && !tab_req.valid
    |=> st_q.ram[6'($past(wr_loc) - GP_BASE)] == $past(s_axi_wdata[7:0]))
    else $error("direct write missed bank 0 storage");
  a_window0_bank0: assert property (wr_take && wr_in_map && s_axi_wstrb[0]    // RULE_03
    && wr_loc == ADR_WIN0 && st_q.mp0 >= GP_BASE && st_q.mp0 <= GP_LAST && !tab_req.valid
    |=> st_q.ram[6'($past(st_q.mp0) - GP_BASE)] == $past(s_axi_wdata[7:0]))
    else $error("window 0 write missed bank 0 storage");

  c_window1_bank1: cover property (wr_take && wr_loc == ADR_WIN1 && st_q.bank);
  c_pcl_jump: cover property (pc_jump ##1 dummy_cycle);
  c_halt_then_clear: cover property (sys_ev.halt ##[1:20] sys_ev.watchdog_clear_instruction);
  c_pd_wdt_reset: cover property (sys_ev.wdt_reset && sys_ev.in_power_down);
  c_table_read: cover property (tab_req.valid);
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import dmcore_pkg::*;

  logic              aclk = 1'b0;
  logic              aresetn = 1'b0;
  logic [31:0]       awaddr = '0, wdata = '0, araddr = '0, rdata;
  logic [2:0]        awprot = '0, arprot = '0;
  logic [3:0]        wstrb = 4'hf;
  logic              awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic              awready, wready, bvalid, arready, rvalid, pc_jump, dummy_cycle;
  logic [1:0]        bresp, rresp;
  logic [7:0]        pc_target, acc_value, flags_value, acc_m, a, b;
  logic [PROG_W-1:0] table_addr, wrd;
  logic [PAGE_W-1:0] pc_page = 7'h2b;
  logic [5:0]        flg_m = '0;
  logic              dum_due = 1'b0;
  dmcore_alu_req_t   alu_req = '0;
  dmcore_tab_req_t   tab_req = '0;
  dmcore_sys_ev_t    sys_ev = '0;
  logic [33:0]       rq[$];
  logic [1:0]        bq[$];
  logic [7:0]        pq[$];
  logic [7:0]        idle_loc[4] = '{8'h09, 8'h0c, 8'h1a, 8'h3f};
  integer            seed = 45506;
  integer            fail_count = 0;
  integer            samples_checked = 0;

  always #5 aclk = ~aclk;

  dmcore_top u_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(awprot),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(arprot), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .alu_req(alu_req),
    .tab_req(tab_req), .sys_ev(sys_ev), .pc_page(pc_page), .table_addr(table_addr),
    .pc_jump(pc_jump), .pc_target(pc_target), .dummy_cycle(dummy_cycle),
    .acc_value(acc_value), .flags_value(flags_value)
  );

  // verdict and end of run
  task automatic wrap_up();
    if (fail_count == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] la(input logic [7:0] l);
    return {22'h0, l, 2'b00};
  endfunction

  // bus write: address and data offered together, bready held until bvalid
  task automatic wr(input logic [31:0] ad, input logic [7:0] d,
                    input logic [1:0] er = RESP_OKAY, input logic [3:0] st = 4'hf);
    @(posedge aclk);
    bq.push_back(er);
    awaddr <= ad;
    awprot <= 3'($random(seed));
    wdata <= {24'($random(seed)), d};
    wstrb <= st;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge aclk); while (!(awready && wready));
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
  endtask

  // bus read: rready held until rvalid
  task automatic rd(input logic [31:0] ad, input logic [7:0] d,
                    input logic [1:0] er = RESP_OKAY);
    @(posedge aclk);
    rq.push_back({er, 24'h0, d});
    araddr <= ad;
    arprot <= 3'($random(seed));
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
  endtask

  // one-cycle system event pulse; the power-down level stays
  task automatic ev(input logic [4:0] e);
    @(posedge aclk);
    sys_ev <= e;
    @(posedge aclk);
    sys_ev[4:1] <= 4'h0;
  endtask

  // alu request with the expected accumulator and flags worked out alongside
  task automatic aop(input dmcore_alu_op_t op, input logic [7:0] v);
    logic [8:0] r;
    logic [4:0] h;
    logic [7:0] bb;
    logic       ci;
    bb = (op == DMCORE_SUB) ? ~v : v;
    ci = (op == DMCORE_SUB);
    h = {1'b0, acc_m[3:0]} + {1'b0, bb[3:0]} + 5'(ci);
    case (op)
      DMCORE_AND: r = {1'b0, acc_m & v};
      DMCORE_OR:  r = {1'b0, acc_m | v};
      DMCORE_XOR: r = {1'b0, acc_m ^ v};
      DMCORE_RLC: r = {acc_m, flg_m[0]};
      DMCORE_RRC: r = {acc_m[0], flg_m[0], acc_m[7:1]};
      DMCORE_LDA: r = {1'b0, v};
      default:    r = {1'b0, acc_m} + {1'b0, bb} + 9'(ci);
    endcase
    if (op inside {DMCORE_AND, DMCORE_OR, DMCORE_XOR})
      flg_m[2] = (r[7:0] == 8'h00);
    if (op inside {DMCORE_RLC, DMCORE_RRC})
      flg_m[0] = r[8];
    if (op inside {DMCORE_ADD, DMCORE_SUB})
      flg_m[3:0] = {(acc_m[7] == bb[7]) && (r[7] != acc_m[7]), r[7:0] == 8'h00, h[4], r[8]};
    acc_m = r[7:0];
    @(posedge aclk);
    alu_req <= '{1'b1, op, v};
    @(posedge aclk);
    alu_req.valid <= 1'b0;
  endtask

  // watcher: each result against the oldest note
  always @(posedge aclk)
  begin
    if (bvalid && bready) cmp(34'(bresp), 34'(bq.pop_front()));
    if (rvalid && rready) cmp({rresp, rdata}, rq.pop_front());
    if (dum_due) cmp(34'(dummy_cycle), 34'h1);
    dum_due <= pc_jump;
    if (pc_jump) cmp(34'(pc_target), 34'(pq.pop_front()));
  end

  // hang guard
  initial
  begin
    #300us;
    fail_count++;
    wrap_up();
  end

  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(la(ADR_BANK), 8'h00);
    rd(la(ADR_FLAGS), 8'h00);
    wr(la(ADR_BANK), 8'hff);
    rd(la(ADR_BANK), 8'h01);
    wr(la(GP_BASE), 8'ha5);
    rd(la(GP_BASE), 8'ha5);
    wr(la(ADR_PTR1), GP_BASE);
    rd(la(ADR_WIN1), 8'h00);
    wr(la(ADR_WIN1), 8'h33);
    wr(la(ADR_PTR0), GP_BASE + 8'h01);
    wr(la(ADR_WIN0), 8'h5a);
    rd(la(GP_BASE + 8'h01), 8'h5a);
    wr(la(ADR_BANK), 8'h00);
    rd(la(ADR_WIN1), 8'ha5);
    rd(la(ADR_PTR1), GP_BASE);
    // window 1 aimed at the accumulator from bank 1
    wr(la(ADR_BANK), 8'h01);
    wr(la(ADR_PTR1), ADR_ACC);
    wr(la(ADR_WIN1), 8'h3c);
    rd(la(ADR_ACC), 8'h3c);
    // window 0 aimed at window 1 must stay inert
    wr(la(ADR_PTR0), ADR_WIN1);
    wr(la(ADR_WIN0), 8'h77);
    rd(la(ADR_WIN0), 8'h00);
    rd(la(ADR_ACC), 8'h3c);
    for (int i = 0; i < 4; i++)
    begin
      wr(la(idle_loc[i]), 8'hff);
      rd(la(idle_loc[i]), 8'h00);
    end
    wr(32'h400 | la(GP_BASE), 8'h11, RESP_SLVERR);
    rd(32'h400 | la(GP_BASE), 8'h00, RESP_SLVERR);
    wr(la(GP_BASE), 8'h22, RESP_OKAY, 4'he);
    rd(la(GP_BASE), 8'ha5);
    // system flags
    ev(5'b01000);
    ev(5'b00100);
    wr(la(ADR_FLAGS), 8'hc0);
    rd(la(ADR_FLAGS), 8'h30);
    wr(la(ADR_FLAGS), 8'h0f);
    rd(la(ADR_FLAGS), 8'h3f);
    ev(5'b01000);
    rd(la(ADR_FLAGS), 8'h1f);
    ev(5'b10000);
    rd(la(ADR_FLAGS), 8'h0f);
    ev(5'b00011);
    rd(la(ADR_BANK), 8'h01);
    rd(la(ADR_FLAGS), 8'h2f);
    ev(5'b00010);
    rd(la(ADR_BANK), 8'h00);
    // arithmetic, first pass on boundary operands
    flg_m = 6'h2f;
    for (int i = 0; i < 32; i++)
    begin
      a = (i < 8) ? 8'h80 : 8'($random(seed));
      b = (i < 8) ? 8'h80 : 8'($random(seed));
      wr(la(ADR_FLAGS), {4'h0, a[3:0] ^ b[7:4]});
      flg_m[3:0] = a[3:0] ^ b[7:4];
      aop(DMCORE_LDA, a);
      aop(dmcore_alu_op_t'(3'(i)), b);
      rd(la(ADR_ACC), acc_m);
      rd(la(ADR_FLAGS), {2'b00, flg_m});
    end
    cmp(34'(acc_value), 34'(acc_m));
    cmp(34'(flags_value), 34'({2'b00, flg_m}));
    for (int i = 0; i < 3; i++)
    begin
      b = 8'($random(seed));
      pq.push_back(b);
      wr(la(ADR_PCL), b);
    end
    b = 8'($random(seed));
    wr(la(ADR_TBLP), b);
    rd(la(ADR_TBLP), b);
    pc_page <= 7'($random(seed));
    @(posedge aclk);
    cmp(34'(table_addr), 34'({pc_page, b}));
    wrd = 15'($random(seed));
    tab_req <= '{1'b1, wrd, GP_BASE + 8'h02};
    @(posedge aclk);
    tab_req.valid <= 1'b0;
    rd(la(ADR_TABLE_HIGH_LATCH), {1'b0, wrd[14:8]});
    rd(la(GP_BASE + 8'h02), wrd[7:0]);
    wr(la(ADR_TABLE_HIGH_LATCH), 8'hff);
    rd(la(ADR_TABLE_HIGH_LATCH), {1'b0, wrd[14:8]});
    // mid-run power-on reset with bank 1 selected and watchdog flag set
    wr(la(ADR_BANK), 8'h01);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(la(ADR_BANK), 8'h00);
    rd(la(ADR_FLAGS), 8'h00);
    repeat (4) @(posedge aclk);
    cmp(34'(pq.size()), 34'h0);
    wrap_up();
  end
endmodule
`default_nettype wire
